// *** hdl/flash_read_lookahead.sv ***
// Look-ahead read sequencer between fabric read requests and the flash array block.
// Assumes a fixed-latency array that presents a whole block on ARR_DATA at the end of a fetch.
// Notes on behaviour
// - While reads are served from the buffer, the next block is fetched in background.
// - Inside a data page, the next fetched block is the next linear block.
// - After a page's last data block, the first block of the next page is fetched.
// - While reading spare pages, the next sector's spare page first block is fetched.
// - Advancing past the last sector wraps back to sector zero.
// - Auxiliary block reads fetch the auxiliary block of the next linear page.
// - A mispredicted address holds busy until the running look-ahead ends, then reads.
// - A mispredicted read shows at most nine busy cycles before data arrives.
`timescale 1ns/1ps
`default_nettype none
`include "flash_read_lookahead_params.svh"

module flash_read_lookahead
  import flash_read_lookahead_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic REN,
  input wire rd_addr_type ADDR,
  output logic BUSY,
  output logic RVALID,
  output logic [`FRL_DATA_W-1:0] RDATA,
  output logic ARR_RD,
  output blk_addr_type ARR_ADDR,
  input wire blk_data_type ARR_DATA
);

  localparam int MAX_BUSY = `FRL_MAX_BUSY;
  localparam logic [1:0] CNT_LAST = 2'(`FRL_ARRAY_CYCLES - 1);

  logic rst_meta_n;
  logic rst_n;
  fetch_state_type state_r;
  fetch_state_type state_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  blk_addr_type fetch_r;
  blk_addr_type fetch_nxt;
  blk_addr_type cur_r;
  blk_addr_type cur_nxt;
  blk_addr_type pre_r;
  blk_addr_type pre_nxt;
  blk_addr_type la_addr;
  logic cur_vld_r;
  logic cur_vld_nxt;
  logic pre_vld_r;
  logic pre_vld_nxt;
  blk_data_type cur_data_r;
  blk_data_type cur_data_nxt;
  blk_data_type pre_data_r;
  blk_data_type pre_data_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [`FRL_DATA_W-1:0] rdata_r;
  logic [`FRL_DATA_W-1:0] rdata_nxt;
  logic hit_cur;
  logic hit_pre;
  logic miss;
  logic [3:0] busy_cnt_r;
  logic [3:0] busy_cnt_nxt;

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  lookahead_next_addr u_next (
    .cur(cur_r),
    .nxt(la_addr)
  );

  assign hit_cur = REN && cur_vld_r && (ADDR.b == cur_r);
  assign hit_pre = REN && !hit_cur && pre_vld_r && (ADDR.b == pre_r);
  assign miss = REN && !hit_cur && !hit_pre;
  assign BUSY = miss;
  assign RVALID = rvalid_r;
  assign RDATA = rdata_r;
  assign ARR_RD = (state_r != ST_IDLE);
  assign ARR_ADDR = fetch_r;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    fetch_nxt = fetch_r;
    cur_nxt = cur_r;
    cur_vld_nxt = cur_vld_r;
    cur_data_nxt = cur_data_r;
    pre_nxt = pre_r;
    pre_vld_nxt = pre_vld_r;
    pre_data_nxt = pre_data_r;
    rvalid_nxt = 1'b0;
    rdata_nxt = rdata_r;
    if (hit_cur)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt = cur_data_r[ADDR.word];
    end
    else if (hit_pre)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt = pre_data_r[ADDR.word];
      cur_nxt = pre_r;
      cur_data_nxt = pre_data_r;
      pre_vld_nxt = 1'b0;
    end
    case (state_r)
      ST_IDLE:
      begin
        if (miss)
        begin
          state_nxt = ST_DEMAND;
          fetch_nxt = ADDR.b;
          cnt_nxt = CNT_LAST;
          pre_vld_nxt = 1'b0;
        end
        else if (cur_vld_r && !pre_vld_r)
        begin
          state_nxt = ST_LOOK;
          fetch_nxt = la_addr;
          cnt_nxt = CNT_LAST;
        end
      end
      ST_LOOK, ST_DEMAND:
      begin
        if (cnt_r == 2'h0)
        begin
          state_nxt = ST_IDLE;
          if (state_r == ST_LOOK)
          begin
            pre_nxt = fetch_r;
            pre_data_nxt = ARR_DATA;
            pre_vld_nxt = 1'b1;
          end
          else
          begin
            cur_nxt = fetch_r;
            cur_data_nxt = ARR_DATA;
            cur_vld_nxt = 1'b1;
          end
        end
        else
        begin
          cnt_nxt = cnt_r - 2'h1;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 2'h0;
      fetch_r <= '0;
      cur_r <= '0;
      cur_vld_r <= 1'b0;
      cur_data_r <= '0;
      pre_r <= '0;
      pre_vld_r <= 1'b0;
      pre_data_r <= '0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      fetch_r <= fetch_nxt;
      cur_r <= cur_nxt;
      cur_vld_r <= cur_vld_nxt;
      cur_data_r <= cur_data_nxt;
      pre_r <= pre_nxt;
      pre_vld_r <= pre_vld_nxt;
      pre_data_r <= pre_data_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Counts consecutive busy cycles for the penalty check.
  always_comb
  begin
    busy_cnt_nxt = BUSY ? busy_cnt_r + 4'h1 : 4'h0;
  end

  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_cnt_r <= 4'h0;
    end
    else
    begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  sequence pre_hit_seq;
    hit_pre && !BUSY;
  endsequence

  sequence delivered_seq;
    RVALID && (RDATA == $past(pre_data_r[ADDR.word]));
  endsequence

  AST_PREFETCH: assert property (@(posedge MCLK) disable iff (!rst_n)
    (state_r == ST_IDLE && !miss && cur_vld_r && !pre_vld_r) |=> (state_r == ST_LOOK))
    else $error("Look-ahead fetch did not start.");

  AST_LINEAR: assert property (@(posedge MCLK) disable iff (!rst_n)
    (state_r == ST_LOOK && !cur_r.aux && !cur_r.spare && cur_r.blk != `FRL_LAST_BLK)
    |-> (fetch_r.blk == cur_r.blk + 3'h1 && fetch_r.page == cur_r.page))
    else $error("Look-ahead did not target the next linear block.");

  AST_PAGE: assert property (@(posedge MCLK) disable iff (!rst_n)
    (state_r == ST_LOOK && !cur_r.aux && !cur_r.spare && cur_r.blk == `FRL_LAST_BLK)
    |-> (fetch_r.blk == 3'h0 && fetch_r.page == cur_r.page + 6'h01))
    else $error("Look-ahead did not move to the next page.");

  AST_SPARE: assert property (@(posedge MCLK) disable iff (!rst_n)
    (state_r == ST_LOOK && !cur_r.aux && cur_r.spare && cur_r.sector != `FRL_LAST_SECTOR)
    |-> (fetch_r.spare && fetch_r.blk == 3'h0 && fetch_r.sector == cur_r.sector + 6'h01))
    else $error("Look-ahead did not target the next spare page.");

  AST_WRAP: assert property (@(posedge MCLK) disable iff (!rst_n)
    (state_r == ST_LOOK && cur_r.sector == `FRL_LAST_SECTOR && ((!cur_r.aux && cur_r.spare)
    || (cur_r.page == `FRL_LAST_PAGE && (cur_r.aux || (!cur_r.spare && cur_r.blk == `FRL_LAST_BLK)))))
    |-> (fetch_r.sector == `FRL_FIRST))
    else $error("Look-ahead did not wrap to sector zero.");

  AST_AUX: assert property (@(posedge MCLK) disable iff (!rst_n)
    (state_r == ST_LOOK && cur_r.aux) |-> (fetch_r.aux && fetch_r.page == cur_r.page + 6'h01))
    else $error("Look-ahead did not target the next auxiliary block.");

  AST_MISS: assert property (@(posedge MCLK) disable iff (!rst_n)
    (miss && state_r == ST_LOOK && ADDR.b != fetch_r)
    |=> (BUSY && ($past(cnt_r) == 2'h0 ? state_r == ST_IDLE : state_r == ST_LOOK)))
    else $error("Mispredicted read started before the look-ahead ended.");

  AST_PENALTY: assert property (@(posedge MCLK) disable iff (!rst_n)
    BUSY |-> (busy_cnt_r < 4'(MAX_BUSY)))
    else $error("Busy penalty exceeded nine cycles.");

  AST_HIT: assert property (@(posedge MCLK) disable iff (!rst_n)
    pre_hit_seq |=> delivered_seq)
    else $error("Prefetched block was not delivered at once.");

endmodule

`default_nettype wire

// *** common/flash_read_lookahead_params.svh ***
// Constants for the flash look-ahead read logic: field widths, limits and timing.
// Assumes one 200 MHz clock; included by the package and by the design modules.
`ifndef FLASH_READ_LOOKAHEAD_PARAMS_SVH
`define FLASH_READ_LOOKAHEAD_PARAMS_SVH

`define FRL_WORD_W 2
`define FRL_BLK_W 3
`define FRL_PAGE_W 6
`define FRL_SECTOR_W 6
`define FRL_DATA_W 32
`define FRL_WORDS 4
`define FRL_LAST_BLK 3'h7
`define FRL_LAST_PAGE 6'h3F
`define FRL_LAST_SECTOR 6'h3F
`define FRL_FIRST 6'h00
`define FRL_CLK_PERIOD_NS 5
`define FRL_ARRAY_ACCESS_NS 15
`define FRL_ARRAY_CYCLES ((`FRL_ARRAY_ACCESS_NS + `FRL_CLK_PERIOD_NS - 1) / `FRL_CLK_PERIOD_NS)
`define FRL_MAX_BUSY 9

`endif

// *** common/flash_read_lookahead_pkg.sv ***
// Types shared by the flash look-ahead read logic.
// Assumes the constants header is on the include path.
`include "flash_read_lookahead_params.svh"

package flash_read_lookahead_pkg;

  typedef struct packed {
    logic aux;
    logic spare;
    logic [`FRL_SECTOR_W-1:0] sector;
    logic [`FRL_PAGE_W-1:0] page;
    logic [`FRL_BLK_W-1:0] blk;
  } blk_addr_type;

  typedef struct packed {
    blk_addr_type b;
    logic [`FRL_WORD_W-1:0] word;
  } rd_addr_type;

  typedef logic [`FRL_WORDS-1:0][`FRL_DATA_W-1:0] blk_data_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOOK = 2'h1,
    ST_DEMAND = 2'h2
  } fetch_state_type;

endpackage

// *** hdl/lookahead_next_addr.sv ***
// Computes the block address that the look-ahead fetch targets next.
// Assumes a block address that is already registered; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "flash_read_lookahead_params.svh"

module lookahead_next_addr
  import flash_read_lookahead_pkg::*;
(
  input wire blk_addr_type cur,
  output blk_addr_type nxt
);

  always_comb
  begin
    nxt = cur;
    if (cur.aux)
    begin
      nxt.blk = 3'h0;
      nxt.page = cur.page + 6'h01;
      if (cur.page == `FRL_LAST_PAGE)
      begin
        nxt.sector = (cur.sector == `FRL_LAST_SECTOR) ? `FRL_FIRST : cur.sector + 6'h01;
      end
    end
    else if (cur.spare)
    begin
      nxt.blk = 3'h0;
      nxt.page = `FRL_FIRST;
      nxt.sector = (cur.sector == `FRL_LAST_SECTOR) ? `FRL_FIRST : cur.sector + 6'h01;
    end
    else if (cur.blk == `FRL_LAST_BLK)
    begin
      nxt.blk = 3'h0;
      nxt.page = cur.page + 6'h01;
      if (cur.page == `FRL_LAST_PAGE)
      begin
        nxt.sector = (cur.sector == `FRL_LAST_SECTOR) ? `FRL_FIRST : cur.sector + 6'h01;
      end
    end
    else
    begin
      nxt.blk = cur.blk + 3'h1;
    end
  end

endmodule

`default_nettype wire

// *** test/flash_array_model.sv ***
// Behavioural flash array that answers the block fetches of the look-ahead logic.
// Assumes the address is held for the whole fetch; data is a function of the address and of arr_rd.
`timescale 1ns/1ps
`default_nettype none
`include "flash_read_lookahead_params.svh"

module flash_array_model
  import flash_read_lookahead_pkg::*;
(
  input wire logic arr_rd,
  input wire blk_addr_type arr_addr,
  output blk_data_type arr_data
);
  // Outside a fetch the data is inverted, so stale values are never mistaken for good ones.
  always_comb
  begin
    for (int i = 0; i < `FRL_WORDS; i++)
    begin
      arr_data[i] = {arr_addr, 13'h1A5, 2'(i)} ^ {32{~arr_rd}};
    end
  end
endmodule
`default_nettype wire

// *** test/flash_read_lookahead_bench.sv ***
// Self-checking testbench for the flash look-ahead read logic.
// Assumes the package, the constants header and the array model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "flash_read_lookahead_params.svh"

module flash_read_lookahead_bench
  import flash_read_lookahead_pkg::*;
;
  logic mclk;
  logic rst_n;
  logic ren;
  rd_addr_type addr;
  logic busy;
  logic rvalid;
  logic [`FRL_DATA_W-1:0] rdata;
  logic arr_rd;
  blk_addr_type arr_addr;
  blk_data_type arr_data;
  blk_addr_type last_fetch;
  logic rd_q = 1'b0;
  int error_cnt = 0;
  int checked = 0;

  flash_read_lookahead u_flash_read_lookahead (.MCLK(mclk), .RST_N(rst_n), .REN(ren),
    .ADDR(addr), .BUSY(busy), .RVALID(rvalid), .RDATA(rdata), .ARR_RD(arr_rd),
    .ARR_ADDR(arr_addr), .ARR_DATA(arr_data));
  flash_array_model u_flash_array_model (.arr_rd(arr_rd), .arr_addr(arr_addr),
    .arr_data(arr_data));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Records the address of every fetch as it starts.
  always @(posedge mclk)
  begin
    if (arr_rd && !rd_q)
    begin
      last_fetch <= arr_addr;
    end
    rd_q <= arr_rd;
  end

  function automatic logic [31:0] dat(blk_addr_type b, logic [1:0] w);
    dat = {b, 13'h1A5, w};
  endfunction

  function automatic blk_addr_type nxt(blk_addr_type c);
    nxt = c;
    if (c.spare)
    begin
      nxt.sector = c.sector + 6'h01;
      nxt.page = `FRL_FIRST;
      nxt.blk = 3'h0;
    end
    else if (c.aux || c.blk == `FRL_LAST_BLK)
    begin
      {nxt.sector, nxt.page} = {c.sector, c.page} + 12'h001;
      nxt.blk = 3'h0;
    end
    else
    begin
      nxt.blk = c.blk + 3'h1;
    end
  endfunction

  function automatic rd_addr_type rnd();
    logic [31:0] r;
    r = $urandom;
    rnd = r[18:0];
    if (rnd.b.aux) rnd.b.spare = 1'b0;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    ren = 1'b0;
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Mode 0 expects a miss, 1 a hit, 2 either.
  task automatic rd(input rd_addr_type a, input int mode);
    int n;
    n = 0;
    ren = 1'b1;
    addr = a;
    #1;
    while (busy !== 1'b0 && n < 50)
    begin
      n++;
      @(posedge mclk);
      #2;
    end
    @(posedge mclk);
    #1;
    chk(rvalid, 1);
    chk(rdata, dat(a.b, a.word));
    if (mode == 1) chk(n, 0);
    else chk(n <= 9, 1);
    if (mode == 0) chk(n > 0 && last_fetch === a.b, 1);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #20000;
    error_cnt++;
    end_sim();
  end

  initial
  begin
    rd_addr_type a;
    rd_addr_type b;
    rd_addr_type corner [6] = '{{2'b00, 6'h05, 6'h10, 3'h2, 2'h1},
      {2'b00, 6'h05, 6'h10, 3'h7, 2'h3}, {2'b00, 6'h3F, 6'h3F, 3'h7, 2'h0},
      {2'b01, 6'h3F, 6'h02, 3'h4, 2'h2}, {2'b10, 6'h07, 6'h20, 3'h0, 2'h1},
      {2'b10, 6'h3F, 6'h3F, 3'h0, 2'h3}};
    rst_n = 1'b0;
    ren = 1'b0;
    addr = '0;
    void'($urandom(32'h2bdc));
    repeat (6) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    rd(rnd(), 0);
    $display("test cold_miss done");
    for (int i = 0; i < 26; i++)
    begin
      a = (i < 6) ? corner[i] : rnd();
      rd(a, 2);
      idle(8);
      chk(last_fetch, nxt(a.b));
      b = a;
      b.b = nxt(a.b);
      b.word = 2'(i);
      rd(b, 1);
      b.word = b.word + 2'h1;
      rd(b, 1);
      idle(1);
      b.b.sector = b.b.sector + 6'h20;
      rd(b, 0);
      idle(1);
      $display("test %0d done", i);
    end
    end_sim();
  end
endmodule
`default_nettype wire
